//--- common/timer_ctrl_pkg.sv
/*
 * Timer control constants: offsets, field positions, encodings and reset value.
 * Assumes a 32-bit APB slave port on the timer kernel clock.
 */
// Behaviour
// [RULE1] Writes are half-words or words only; reads may be any width.
// [RULE2] Filter divide field 9:8 selects sample period of one, two or four cycles.
// [RULE3] Reload buffer enable bit 7 routes reload writes to a preload copy.
// [RULE4] Update source select at 1 lets only counter overflow make an update event.
// [RULE5] Update inhibit blocks update events; software trigger still clears counter and prescaler.
// [RULE6] Each non-inhibited update event copies preload values into active shadows.
// [RULE7] Counter run enable bit 0 lets the counter advance; otherwise it holds.
// [RULE8] Interrupt enable bit 1 gates channel-1 interrupt, bit 0 gates update interrupt.
// [RULE9] Overrun flag bit 9 sets when a capture lands while event flag set.
// [RULE10] Compare match sets channel-1 flag; compare above reload sets it at overflow.
// [RULE11] Capture edge stores counter and sets flag; reading compare register clears it.
// [RULE12] Update flag sets on overflow, or on software trigger when select and inhibit are zero.
// [RULE13] Event register bit 1 forces a channel-1 event and self-clears.
// [RULE14] Forced capture copies counter, sets flag, and sets overrun if flag was set.
// [RULE15] Event register bit 0 clears counter and prescaler count and updates registers.
// [RULE16] Software writes reserved bits as zero.
// [RULE17] Interrupt request is high while an enabled flag is set.
// [RULE18] Clear-by-zero flags ignore written ones; a hardware set beats a clear.
package timer_ctrl_pkg;

   // ==========================================================================
   // Register byte offsets
   // ==========================================================================
   localparam logic [7:0] OFS_CONTROL_ONE    = 8'h00;
   localparam logic [7:0] OFS_IRQ_ENABLE     = 8'h0c;
   localparam logic [7:0] OFS_STATUS_FLAGS   = 8'h10;
   localparam logic [7:0] OFS_EVENT_GENERATE = 8'h14;
   localparam logic [7:0] OFS_CHANNEL_CONFIG = 8'h18;
   localparam logic [7:0] OFS_TIMER_COUNT    = 8'h24;
   localparam logic [7:0] OFS_PRESCALE       = 8'h28;
   localparam logic [7:0] OFS_AUTORELOAD     = 8'h2c;
   localparam logic [7:0] OFS_COMPARE_CH1    = 8'h34;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int BIT_COUNTER_RUN_ENABLE   = 0;
   localparam int BIT_UPDATE_INHIBIT       = 1;
   localparam int BIT_UPDATE_SOURCE_SELECT = 2;
   localparam int BIT_RELOAD_BUFFER_ENABLE = 7;
   localparam int LSB_FILTER_CLOCK_DIVIDE  = 8;
   localparam int BIT_UPDATE_IRQ_ENABLE    = 0;
   localparam int BIT_CH1_IRQ_ENABLE       = 1;
   localparam int BIT_UPDATE_FLAG          = 0;
   localparam int BIT_CH1_EVENT_FLAG       = 1;
   localparam int BIT_CH1_OVERRUN_FLAG     = 9;
   localparam int BIT_UPDATE_TRIGGER       = 0;
   localparam int BIT_CH1_EVENT_TRIGGER    = 1;
   localparam int LSB_CHANNEL_MODE         = 0;
   localparam int BIT_COMPARE_BUFFER       = 3;
   localparam int LSB_CAPTURE_EDGE         = 4;
   localparam int BIT_CAPTURE_ENABLE       = 6;

   // ==========================================================================
   // Encodings and reset values
   // ==========================================================================
   localparam logic [1:0] MODE_COMPARE   = 2'h0;
   localparam logic [1:0] MODE_CAPTURE   = 2'h1;
   localparam logic [1:0] EDGE_RISING    = 2'h0;
   localparam logic [1:0] EDGE_FALLING   = 2'h1;
   localparam logic [1:0] EDGE_BOTH      = 2'h3;
   localparam logic [1:0] DIVIDE_BY_ONE  = 2'h0;
   localparam logic [1:0] DIVIDE_BY_TWO  = 2'h1;
   localparam logic [1:0] DIVIDE_BY_FOUR = 2'h2;
   localparam logic [1:0] DIV_LIMIT_ONE  = 2'h0;
   localparam logic [1:0] DIV_LIMIT_TWO  = 2'h1;
   localparam logic [1:0] DIV_LIMIT_FOUR = 2'h3;
   localparam logic [15:0] RESET_WORD    = 16'h0000;

endpackage

//--- rtl/capture_sampler.sv
/*
 * Samples the capture input at the filter rate; one-cycle pulse per selected edge.
 * Assumes the input is synchronous to the kernel clock.
 */
`timescale 1ns/10ps
module capture_sampler
   import timer_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] divide_sel,
   input  wire logic [1:0] edge_sel,
   input  wire logic       level_in,
   output logic            edge_pulse
);

   typedef struct packed {
      logic [1:0] div_count;
      logic       last_sample;
      logic       pulse;
   } sampler_state_t;

   sampler_state_t state;
   sampler_state_t next_state;
   logic [1:0]     div_limit;
   logic           sample_en;
   logic           rise;
   logic           fall;

   // ==========================================================================
   // Sampling clock divider
   // ==========================================================================
   // The reserved divide code falls back to one period so the filter never stalls.
   always_comb begin
      unique case (divide_sel)
         DIVIDE_BY_TWO:  div_limit = DIV_LIMIT_TWO;  // [RULE2]
         DIVIDE_BY_FOUR: div_limit = DIV_LIMIT_FOUR; // [RULE2]
         default:        div_limit = DIV_LIMIT_ONE;  // [RULE2]
      endcase
   end

   assign sample_en = (state.div_count >= div_limit);
   assign rise      = level_in & ~state.last_sample;
   assign fall      = ~level_in & state.last_sample;

   always_comb begin
      next_state       = state;
      next_state.pulse = 1'b0;
      if (sample_en) begin
         next_state.div_count   = 2'h0;
         next_state.last_sample = level_in;
         unique case (edge_sel)
            EDGE_FALLING: next_state.pulse = fall;
            EDGE_BOTH:    next_state.pulse = rise | fall;
            default:      next_state.pulse = rise;
         endcase
      end else begin
         next_state.div_count = state.div_count + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign edge_pulse = state.pulse;

endmodule

//--- rtl/timer_ctrl.sv
/*
 * Single-channel 16-bit timer: control, status and event registers behind APB.
 * Assumes APB runs on CLK_SYS and all inputs are synchronous to it.
 */
`timescale 1ns/10ps
module timer_ctrl
   import timer_ctrl_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        CAPTURE_IN,
   output logic             TIMER_IRQ,
   output logic             UPDATE_EVENT,
   output logic      [15:0] TIMER_COUNT
);

   typedef struct packed {
      logic        counter_run_enable;
      logic        update_inhibit;
      logic        update_source_select;
      logic        reload_buffer_enable;
      logic [1:0]  filter_clock_divide;
      logic        ch1_irq_enable;
      logic        update_irq_enable;
      logic        ch1_overrun_flag;
      logic        ch1_event_flag;
      logic        update_flag;
      logic [1:0]  channel_mode;
      logic        compare_buffer;
      logic [1:0]  capture_edge;
      logic        capture_enable;
      logic [15:0] timer_count;
      logic [15:0] prescale_count;
      logic [15:0] prescale_preload;
      logic [15:0] prescale_active;
      logic [15:0] reload_preload;
      logic [15:0] reload_active;
      logic [15:0] compare_preload;
      logic [15:0] compare_active;
      logic        update_pulse;
      logic [31:0] rdata;
   } timer_state_t;

   timer_state_t state;
   timer_state_t next_state;

   logic        setup_phase;
   logic        access_phase;
   logic        addr_known;
   logic        write_refused;
   logic        wr;
   logic        rd;
   logic [15:0] wdata;
   logic        capture_edge_pulse;
   logic        tick;
   logic        overflow;
   logic        update_trigger;
   logic        ch1_trigger;
   logic        update_event;
   logic        reg_update;
   logic        capture_mode;
   logic        capture_now;
   logic        compare_hit;

   // Register word as software reads it.
   function automatic logic [15:0] read_word(input timer_state_t s, input logic [7:0] addr);
      logic [15:0] w;
      w = RESET_WORD;
      unique case (addr)
         OFS_CONTROL_ONE: begin
            w[BIT_COUNTER_RUN_ENABLE]       = s.counter_run_enable;
            w[BIT_UPDATE_INHIBIT]           = s.update_inhibit;
            w[BIT_UPDATE_SOURCE_SELECT]     = s.update_source_select;
            w[BIT_RELOAD_BUFFER_ENABLE]     = s.reload_buffer_enable;
            w[LSB_FILTER_CLOCK_DIVIDE +: 2] = s.filter_clock_divide;
         end
         OFS_IRQ_ENABLE: begin
            w[BIT_CH1_IRQ_ENABLE]    = s.ch1_irq_enable;
            w[BIT_UPDATE_IRQ_ENABLE] = s.update_irq_enable;
         end
         OFS_STATUS_FLAGS: begin
            w[BIT_CH1_OVERRUN_FLAG] = s.ch1_overrun_flag;
            w[BIT_CH1_EVENT_FLAG]   = s.ch1_event_flag;
            w[BIT_UPDATE_FLAG]      = s.update_flag;
         end
         OFS_CHANNEL_CONFIG: begin
            w[LSB_CHANNEL_MODE +: 2] = s.channel_mode;
            w[BIT_COMPARE_BUFFER]    = s.compare_buffer;
            w[LSB_CAPTURE_EDGE +: 2] = s.capture_edge;
            w[BIT_CAPTURE_ENABLE]    = s.capture_enable;
         end
         OFS_TIMER_COUNT: w = s.timer_count;
         OFS_PRESCALE:    w = s.prescale_preload;
         OFS_AUTORELOAD:  w = s.reload_buffer_enable ? s.reload_preload : s.reload_active;
         OFS_COMPARE_CH1: begin
            if (s.compare_buffer && s.channel_mode == MODE_COMPARE) begin
               w = s.compare_preload;
            end else begin
               w = s.compare_active;
            end
         end
         default: w = RESET_WORD;
      endcase
      return w;
   endfunction

   // ==========================================================================
   // APB slave decode
   // ==========================================================================
   // Zero wait states; read data is latched in the setup cycle so PRDATA is a flop.
   assign setup_phase  = PSEL & ~PENABLE;
   assign access_phase = PSEL & PENABLE;
   assign wdata        = PWDATA[15:0];

   always_comb begin
      unique case (PADDR)
         OFS_CONTROL_ONE, OFS_IRQ_ENABLE, OFS_STATUS_FLAGS, OFS_EVENT_GENERATE,
         OFS_CHANNEL_CONFIG, OFS_TIMER_COUNT, OFS_PRESCALE, OFS_AUTORELOAD,
         OFS_COMPARE_CH1: addr_known = 1'b1;
         default:         addr_known = 1'b0;
      endcase
   end

   // Byte writes cannot carry a whole half-word, so they are refused with an error.
   assign write_refused = PWRITE & (PSTRB[1:0] != 2'h3); // [RULE1]
   assign wr            = access_phase & PWRITE & addr_known & ~write_refused;
   assign rd            = access_phase & ~PWRITE & addr_known;
   assign PREADY        = 1'b1;
   assign PSLVERR       = access_phase & (~addr_known | write_refused);

   // ==========================================================================
   // Filter sampling and edge detection
   // ==========================================================================
   capture_sampler u_sampler (
      .clk        (CLK_SYS),
      .rst_n      (RST_N),
      .divide_sel (state.filter_clock_divide),
      .edge_sel   (state.capture_edge),
      .level_in   (CAPTURE_IN),
      .edge_pulse (capture_edge_pulse)
   );

   // ==========================================================================
   // Counting and events
   // ==========================================================================
   assign capture_mode   = (state.channel_mode == MODE_CAPTURE);
   assign update_trigger = wr & (PADDR == OFS_EVENT_GENERATE) & wdata[BIT_UPDATE_TRIGGER];
   assign ch1_trigger    = wr & (PADDR == OFS_EVENT_GENERATE) & wdata[BIT_CH1_EVENT_TRIGGER]; // [RULE13]
   assign tick           = state.counter_run_enable & (state.prescale_count == state.prescale_active); // [RULE7]
   assign overflow       = tick & (state.timer_count >= state.reload_active);
   // Registers reload on any non-inhibited source; the select bit only narrows the flag and the UPDATE_EVENT pulse.
   assign reg_update     = (overflow | update_trigger) & ~state.update_inhibit; // [RULE5] [RULE15]
   assign update_event   = (overflow | (update_trigger & ~state.update_source_select))
                           & ~state.update_inhibit; // [RULE4]
   assign capture_now    = capture_mode & ((state.capture_enable & capture_edge_pulse) | ch1_trigger);
   assign compare_hit    = ~capture_mode & tick &
                           (state.compare_active > state.reload_active ? overflow :
                            (overflow ? state.compare_active == 16'h0000 :
                             state.compare_active == state.timer_count + 16'h0001)); // [RULE10]

   always_comb begin
      next_state              = state;
      next_state.update_pulse = update_event;

      // Counter and prescaler.
      if (tick) begin
         next_state.prescale_count = 16'h0000;
         next_state.timer_count    = overflow ? 16'h0000 : state.timer_count + 16'h0001;
      end else if (state.counter_run_enable) begin
         next_state.prescale_count = state.prescale_count + 16'h0001; // [RULE7]
      end
      if (update_trigger) begin
         next_state.prescale_count = 16'h0000; // [RULE5] [RULE15]
         next_state.timer_count    = 16'h0000; // [RULE15]
      end

      // Shadow loads on a permitted update.
      if (reg_update) begin
         next_state.prescale_active = state.prescale_preload; // [RULE6]
         next_state.reload_active   = state.reload_preload;   // [RULE6] [RULE3]
         if (state.compare_buffer && !capture_mode) begin
            next_state.compare_active = state.compare_preload; // [RULE6]
         end
      end

      // Register writes.
      if (wr) begin
         unique case (PADDR)
            OFS_CONTROL_ONE: begin
               next_state.counter_run_enable   = wdata[BIT_COUNTER_RUN_ENABLE];
               next_state.update_inhibit       = wdata[BIT_UPDATE_INHIBIT];
               next_state.update_source_select = wdata[BIT_UPDATE_SOURCE_SELECT];
               next_state.reload_buffer_enable = wdata[BIT_RELOAD_BUFFER_ENABLE];
               next_state.filter_clock_divide  = wdata[LSB_FILTER_CLOCK_DIVIDE +: 2]; // [RULE2]
            end
            OFS_IRQ_ENABLE: begin
               next_state.ch1_irq_enable    = wdata[BIT_CH1_IRQ_ENABLE];    // [RULE8]
               next_state.update_irq_enable = wdata[BIT_UPDATE_IRQ_ENABLE]; // [RULE8]
            end
            OFS_STATUS_FLAGS: begin
               // Clear-by-zero: a written one leaves the flag alone.
               next_state.ch1_overrun_flag = state.ch1_overrun_flag & wdata[BIT_CH1_OVERRUN_FLAG]; // [RULE18]
               next_state.ch1_event_flag   = state.ch1_event_flag & wdata[BIT_CH1_EVENT_FLAG];     // [RULE18]
               next_state.update_flag      = state.update_flag & wdata[BIT_UPDATE_FLAG];           // [RULE18]
            end
            OFS_CHANNEL_CONFIG: begin
               next_state.channel_mode   = wdata[LSB_CHANNEL_MODE +: 2];
               next_state.compare_buffer = wdata[BIT_COMPARE_BUFFER];
               next_state.capture_edge   = wdata[LSB_CAPTURE_EDGE +: 2];
               next_state.capture_enable = wdata[BIT_CAPTURE_ENABLE];
            end
            OFS_TIMER_COUNT: begin
               if (!update_trigger) begin
                  next_state.timer_count = wdata;
               end
            end
            OFS_PRESCALE: next_state.prescale_preload = wdata;
            OFS_AUTORELOAD: begin
               next_state.reload_preload = wdata; // [RULE3]
               if (!state.reload_buffer_enable) begin
                  next_state.reload_active = wdata; // [RULE3]
               end
            end
            OFS_COMPARE_CH1: begin
               next_state.compare_preload = wdata;
               if (!state.compare_buffer || capture_mode) begin
                  next_state.compare_active = wdata;
               end
            end
            default: begin
            end
         endcase
      end

      // Reading the capture register acknowledges the capture.
      if (rd && PADDR == OFS_COMPARE_CH1 && capture_mode) begin
         next_state.ch1_event_flag = 1'b0; // [RULE11]
      end

      // Hardware sets come last so they win over a clear in the same cycle.
      if (capture_now) begin
         next_state.compare_active = state.timer_count;     // [RULE11] [RULE14]
         next_state.ch1_event_flag = 1'b1;                  // [RULE11] [RULE14]
         if (state.ch1_event_flag) begin
            next_state.ch1_overrun_flag = 1'b1;             // [RULE9] [RULE14] [RULE18]
         end
      end
      if (compare_hit || (ch1_trigger && !capture_mode)) begin
         next_state.ch1_event_flag = 1'b1;                  // [RULE10] [RULE13] [RULE18]
      end
      if (update_event) begin
         next_state.update_flag = 1'b1;                     // [RULE12] [RULE18]
      end

      if (setup_phase) begin
         next_state.rdata = {16'h0000, read_word(state, PADDR)};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign PRDATA       = state.rdata;
   assign TIMER_IRQ    = (state.ch1_event_flag & state.ch1_irq_enable) |
                         (state.update_flag & state.update_irq_enable); // [RULE17] [RULE8]
   assign UPDATE_EVENT = state.update_pulse;
   assign TIMER_COUNT  = state.timer_count;

endmodule

//--- tb/timer_ctrl_properties.sv
/* Port-level checks for timer_ctrl, attached by bind.
   Assumes a well-formed APB master and one clock domain. */
`timescale 1ns/10ps
module timer_ctrl_checker
   import timer_ctrl_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0]  PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic        PSLVERR,
   input wire logic        TIMER_IRQ,
   input wire logic        UPDATE_EVENT,
   input wire logic [15:0] TIMER_COUNT
);
   // ==========================================================================
   // Shadow of the software-written control fields
   // ==========================================================================
   typedef struct packed {
      logic [15:0] ctrl;
      logic [1:0]  ien;
   } shadow_t;
   shadow_t sh;
   shadow_t next_sh;
   logic    wacc;
   logic    racc;
   logic    trig;
   assign wacc = PSEL && PENABLE && PWRITE && (PSTRB[1:0] == 2'h3);
   assign racc = PSEL && PENABLE && !PWRITE;
   assign trig = wacc && (PADDR == OFS_EVENT_GENERATE) && PWDATA[0];
   always_comb begin
      next_sh = sh;
      if (wacc && PADDR == OFS_CONTROL_ONE) begin
         next_sh.ctrl = PWDATA[15:0];
      end
      if (wacc && PADDR == OFS_IRQ_ENABLE) begin
         next_sh.ien = PWDATA[1:0];
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sh <= '0;
      end else begin
         sh <= next_sh;
      end
   end
   // ==========================================================================
   // Properties
   // ==========================================================================
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   bad_addr_err_a: assert property (PSEL && PENABLE && !(PADDR inside {8'h00, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h24, 8'h28, 8'h2c, 8'h34}) |-> PSLVERR) else $error("unmapped access without error");
   narrow_write_err_a: assert property (PSEL && PENABLE && PWRITE && PSTRB[1:0] != 2'h3 |-> PSLVERR)
      else $error("narrow write without error");
   ctrl_readback_a: assert property (racc && PADDR == OFS_CONTROL_ONE |->
      (PRDATA[15:0] & 16'h0387) == (sh.ctrl & 16'h0387)) else $error("control readback wrong");
   ien_readback_a: assert property (racc && PADDR == OFS_IRQ_ENABLE |-> PRDATA[1:0] == sh.ien)
      else $error("enable readback wrong");
   irq_masked_a: assert property (sh.ien == 2'h0 |-> !TIMER_IRQ) else $error("irq while disabled");
   count_hold_a: assert property (!sh.ctrl[0] && !wacc |=> $stable(TIMER_COUNT))
      else $error("counter moved while stopped");
   trigger_clear_a: assert property (trig |=> TIMER_COUNT == 16'h0000) else $error("trigger left count");
   trig_pulse_a: assert property (trig && !sh.ctrl[2] && !sh.ctrl[1] |-> ##[1:2] UPDATE_EVENT)
      else $error("no update pulse after trigger");
   trig_quiet_a: assert property (trig && (sh.ctrl[2] || sh.ctrl[1]) && !sh.ctrl[0] |=>
      !UPDATE_EVENT [*2]) else $error("update pulse while suppressed");
   evt_read_zero_a: assert property (racc && PADDR == OFS_EVENT_GENERATE |-> PRDATA == 32'h0)
      else $error("event register not zero");
endmodule
bind timer_ctrl timer_ctrl_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .TIMER_IRQ(TIMER_IRQ), .UPDATE_EVENT(UPDATE_EVENT), .TIMER_COUNT(TIMER_COUNT));

//--- tb/timer_ctrl_tb.sv
/* Self-checking bench for timer_ctrl over APB.
   Assumes zero-wait or waiting APB slave; every wait is bounded. */
`timescale 1ns/10ps
module timer_ctrl_tb
   import timer_ctrl_pkg::*;
();
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic        capture_in = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timer_irq;
   logic        update_event;
   logic [15:0] timer_count;
   logic [31:0] r;
   logic        e;
   logic [15:0] c;
   int          fails = 0;
   int          check_count = 0;
   always #20 clk_sys = ~clk_sys;
   timer_ctrl dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CAPTURE_IN(capture_in), .TIMER_IRQ(timer_irq), .UPDATE_EVENT(update_event), .TIMER_COUNT(timer_count));
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      for (int n = 1; pready !== 1'b1 && n < 16; n++) @(posedge clk_sys);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk("pready", 1, pready);
         tally_and_finish;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 4'hf);
      chk(nm, x, r & m);
   endtask
   task wait_irq;
      for (int n = 0; timer_irq !== 1'b1 && n < 200; n++) @(negedge clk_sys);
      if (timer_irq !== 1'b1) begin
         chk("timer_irq", 1, timer_irq);
         tally_and_finish;
      end
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task t_reset;
      rdc("control_one", OFS_CONTROL_ONE, 32'hffffffff, 32'h0);
      rdc("irq_enable", OFS_IRQ_ENABLE, 32'hffffffff, 32'h0);
      rdc("status_flags", OFS_STATUS_FLAGS, 32'hffffffff, 32'h0);
      rdc("event_generate", OFS_EVENT_GENERATE, 32'hffffffff, 32'h0);
      $display("test reset done");
   endtask
   task t_access;
      apb(1'b0, 8'h04, 32'h0, 4'hf);
      chk("pslverr unmapped", 1, e);
      apb(1'b1, OFS_CONTROL_ONE, 32'h0080, 4'h1);
      chk("pslverr byte write", 1, e);
      rdc("control_one", OFS_CONTROL_ONE, 32'hffff, 32'h0);
      apb(1'b1, OFS_CONTROL_ONE, 32'h0386, 4'h3);
      chk("pslverr half write", 0, e);
      rdc("control_one", OFS_CONTROL_ONE, 32'h0387, 32'h0386);
      $display("test access done");
   endtask
   task t_update;
      wr(OFS_CONTROL_ONE, 32'h0);
      wr(OFS_AUTORELOAD, 32'd100);
      wr(OFS_PRESCALE, 32'h0);
      wr(OFS_CONTROL_ONE, 32'h1);
      repeat (10) @(posedge clk_sys);
      wr(OFS_CONTROL_ONE, 32'h0);
      @(negedge clk_sys);
      c = timer_count;
      repeat (5) @(negedge clk_sys);
      chk("count held", {16'h0, c}, {16'h0, timer_count});
      chk("count moved", 1, c != 16'h0);
      wr(OFS_EVENT_GENERATE, 32'h1);
      rdc("count cleared", OFS_TIMER_COUNT, 32'hffff, 32'h0);
      rdc("update_flag", OFS_STATUS_FLAGS, 32'h1, 32'h1);
      wr(OFS_STATUS_FLAGS, 32'h1);
      rdc("update_flag kept", OFS_STATUS_FLAGS, 32'h1, 32'h1);
      wr(OFS_STATUS_FLAGS, 32'h0);
      rdc("update_flag cleared", OFS_STATUS_FLAGS, 32'h1, 32'h0);
      for (int i = 1; i < 3; i++) begin
         wr(OFS_CONTROL_ONE, 32'(2 * i));
         wr(OFS_EVENT_GENERATE, 32'h1);
         rdc("update_flag suppressed", OFS_STATUS_FLAGS, 32'h1, 32'h0);
      end
      $display("test update done");
   endtask
   task t_compare;
      wr(OFS_CONTROL_ONE, 32'h0);
      wr(OFS_AUTORELOAD, 32'd20);
      wr(OFS_COMPARE_CH1, 32'd5);
      wr(OFS_CHANNEL_CONFIG, {30'h0, MODE_COMPARE});
      wr(OFS_EVENT_GENERATE, 32'h1);
      wr(OFS_STATUS_FLAGS, 32'h0);
      wr(OFS_IRQ_ENABLE, 32'h2);
      rdc("irq_enable", OFS_IRQ_ENABLE, 32'h3, 32'h2);
      chk("irq idle", 0, timer_irq);
      wr(OFS_CONTROL_ONE, 32'h1);
      wait_irq;
      c = timer_count;
      chk("match count", 1, c == 16'd5 || c == 16'd6);
      wr(OFS_CONTROL_ONE, 32'h0);
      rdc("ch1_event_flag", OFS_STATUS_FLAGS, 32'h2, 32'h2);
      wr(OFS_IRQ_ENABLE, 32'h1);
      @(negedge clk_sys);
      chk("irq masked", 0, timer_irq);
      wr(OFS_STATUS_FLAGS, 32'h0);
      wr(OFS_COMPARE_CH1, 32'd30);
      wr(OFS_IRQ_ENABLE, 32'h2);
      wr(OFS_CONTROL_ONE, 32'h1);
      wait_irq;
      c = timer_count;
      wr(OFS_CONTROL_ONE, 32'h0200);
      chk("overflow count", 1, c < 16'd2);
      $display("test compare done");
   endtask
   task t_capture;
      wr(OFS_STATUS_FLAGS, 32'h0);
      wr(OFS_CHANNEL_CONFIG, 32'h41);
      @(negedge clk_sys);
      c = timer_count;
      wr(OFS_EVENT_GENERATE, 32'h2);
      rdc("forced capture", OFS_STATUS_FLAGS, 32'h202, 32'h002);
      rdc("capture value", OFS_COMPARE_CH1, 32'hffff, {16'h0, c});
      rdc("read clears flag", OFS_STATUS_FLAGS, 32'h2, 32'h0);
      wr(OFS_EVENT_GENERATE, 32'h2);
      wr(OFS_EVENT_GENERATE, 32'h2);
      rdc("overrun", OFS_STATUS_FLAGS, 32'h202, 32'h202);
      wr(OFS_STATUS_FLAGS, 32'h0);
      capture_in <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rdc("edge capture", OFS_STATUS_FLAGS, 32'h202, 32'h002);
      $display("test capture done");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset;
      t_access;
      t_update;
      t_compare;
      t_capture;
      tally_and_finish;
   end
endmodule
